// ===== bst_params.svh
/*
  constants of the boundary-scan test access block: instruction codes,
  scan lengths, key values, register offsets and reset values.
  assumes it is included by its bare name from the package and modules.
*/
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

// instruction register
`define BST_IR_W          10
`define BST_IR_CAPTURE    10'h001
`define BST_OP_BYPASS     10'h3FF
`define BST_OP_IDCODE     10'h006
`define BST_OP_SAMPLE     10'h005
`define BST_OP_EXTEST     10'h00F
`define BST_OP_USERCODE   10'h007
`define BST_OP_HIGHZ      10'h00B
`define BST_OP_CLAMP      10'h00A
`define BST_OP_SCANEN     10'h013
`define BST_OP_HALT       10'h201

// data register lengths
`define BST_DR_MAX        34
`define BST_LEN_W         6
`define BST_LEN_BYPASS    6'h01
`define BST_LEN_WORD      6'h20
`define BST_LEN_SCANEN    6'h08
`define BST_LEN_HALT      6'h22
`define BST_LEN_BSR       6'h10

// key values
`define BST_SCANEN_KEY    8'h01
`define BST_HALT_KEY1     34'h3_0000_0000
`define BST_HALT_KEY2     34'h1_0000_0005

// boundary pins, four cells per pin
`define BST_PINS          4
`define BST_BSR_W         16
`define BST_DIFF_MASK     4'hC
`define BST_SYNC_W        8
`define BST_SYNC_RST      8'h0E

// apb register map
`define BST_ADDR_W        12
`define BST_OFF_CTRL      12'h000
`define BST_OFF_STATUS    12'h004
`define BST_OFF_USERCODE  12'h008
`define BST_OFF_IDCODE    12'h00C
`define BST_OFF_PINS      12'h010
`define BST_CTRL_RST      3'h0
`define BST_USERCODE_RST  32'hFFFF_FFFF

`endif

// ===== bst_pkg.sv
/*
  types of the boundary-scan test access block: tap state enum and the
  bus and pin carriers.
  assumes bst_params.svh is on the include path.
*/
package bst_pkg;
`include "bst_params.svh"

    typedef enum logic [15:0] {
        TAP_TLR   = 16'h0001,
        TAP_RTI   = 16'h0002,
        TAP_SELDR = 16'h0004,
        TAP_CAPDR = 16'h0008,
        TAP_SHDR  = 16'h0010,
        TAP_EX1DR = 16'h0020,
        TAP_PADR  = 16'h0040,
        TAP_EX2DR = 16'h0080,
        TAP_UPDR  = 16'h0100,
        TAP_SELIR = 16'h0200,
        TAP_CAPIR = 16'h0400,
        TAP_SHIR  = 16'h0800,
        TAP_EX1IR = 16'h1000,
        TAP_PAIR  = 16'h2000,
        TAP_EX2IR = 16'h4000,
        TAP_UPIR  = 16'h8000
    } bst_tap_e;

    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`BST_ADDR_W-1:0] paddr;
        logic [31:0]            pwdata;
    } bst_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } bst_apb_rsp_s;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_jtag_in_s;

    typedef struct packed {
        logic tdo;
        logic tdo_oe_n;
    } bst_jtag_out_s;
endpackage

// ===== bst_sync.sv
/*
  two-flop synchroniser for the pins that enter the block.
  assumes inputs are asynchronous to sys_clk; only stage two is read.
*/
`timescale 1ns/1ps
`include "bst_params.svh"
module bst_sync (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // raw and synchronised levels
    input  wire logic [`BST_SYNC_W-1:0] d,
    output logic      [`BST_SYNC_W-1:0] q
);
    typedef struct packed {
        logic [`BST_SYNC_W-1:0] s1;
        logic [`BST_SYNC_W-1:0] s2;
    } bst_sync_s;

    bst_sync_s st_r;
    bst_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '{s1: `BST_SYNC_RST, s2: `BST_SYNC_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule

// ===== bst_tap.sv
/*
  boundary-scan test access port: tap state machine on sampled tck,
  instruction and data registers, boundary cells, halt and scan-enable
  sequences, and an apb slave for control and status.
  assumes tck, tms, tdi, config_restart_n and pins are asynchronous;
  core_out and core_oe_n come from logic on sys_clk.
*/
`timescale 1ns/1ps
`include "bst_params.svh"
// Functional notes
// RULE1: bypass, id, sample run without halting configuration
// RULE2: halt needs instruction 0x201 then two scans
// RULE3: restart input low halts; then all instructions
// RULE4: dummy bit precedes each segment, value unknown
// RULE5: processor tap joins only after configuration
// RULE6: tester holds fixed values in dedicated cells
// RULE7: direction cell zero drives, one captures
// RULE8: scan circuitry enabled by configuration or key
// RULE9: tester shifts 0x013 then data 0x01
// RULE10: test port always on, no disable
// RULE11: instruction capture shifts out 1 then 0
// RULE12: tester reaches shift-ir with tms 01100
// RULE13: tester preloads before first external test; bench loads extest in t_halt before any preload
// RULE14: output-enable zero drives output data onto pin
// RULE15: no external test during reconfiguration
// RULE16: differential pins internal after configuration
// RULE17: reset state loads identification instruction
// RULE18: scan-enable register eight bits, key 0x01
// RULE19: standard tap machine, tdo on falling edge
module bst_tap #(
    parameter logic [31:0] IDCODE_VALUE = 32'h0A5A_5001  // arbitrary value
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // test port
    input  wire bst_pkg::bst_jtag_in_s jtag_in,
    output bst_pkg::bst_jtag_out_s     jtag_out,
    // configuration
    input  wire logic                  config_restart_n,
    output logic                       config_halt,
    output logic                       hard_processor_system_join,
    // boundary pins
    input  wire logic [`BST_PINS-1:0]  pin_in,
    input  wire logic [`BST_PINS-1:0]  core_out,
    input  wire logic [`BST_PINS-1:0]  core_oe_n,
    output logic      [`BST_PINS-1:0]  pin_out,
    output logic      [`BST_PINS-1:0]  pin_oe_n,
    // register bus
    input  wire bst_pkg::bst_apb_req_s apb_req,
    output bst_pkg::bst_apb_rsp_s      apb_rsp
);
    import bst_pkg::*;

    typedef struct packed {
        bst_tap_e               st;
        logic [`BST_IR_W-1:0]   ir;
        logic [`BST_IR_W-1:0]   ir_sh;
        logic [`BST_DR_MAX-1:0] dr_sh;
        logic                   proc_bit;
        logic                   tck_d;
        logic                   tdo;
        logic                   tdo_oe_n;
        logic [`BST_PINS-1:0]   output_enable_update_reg;
        logic [`BST_PINS-1:0]   output_data_update_reg;
        logic [`BST_PINS-1:0]   pin_out;
        logic [`BST_PINS-1:0]   pin_oe_n;
        logic                   scan_en;
        logic                   halt_step;
        logic                   halt_cmd;
        logic                   config_halt;
        logic                   proc_join;
        logic [2:0]             ctrl;
        logic [31:0]            usercode;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } bst_state_s;

    bst_state_s q;
    bst_state_s nxt;

    logic [`BST_SYNC_W-1:0] sync_q;
    logic                   tck_s;
    logic                   tms_s;
    logic                   tdi_s;
    logic                   restart_s;
    logic [`BST_PINS-1:0]   pin_s;
    logic                   tck_rise;
    logic                   tck_fall;
    logic                   bst_en;
    logic                   test_drive;
    logic                   fab_tdi;
    logic [`BST_LEN_W-1:0]  dr_len;
    logic [`BST_BSR_W-1:0]  bsr_cap;
    logic [`BST_PINS-1:0]   internal;

    bst_sync u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({pin_in, config_restart_n, jtag_in.tdi, jtag_in.tms, jtag_in.tck}),
        .q       (sync_q)
    );

    assign tck_s     = sync_q[0];
    assign tms_s     = sync_q[1];
    assign tdi_s     = sync_q[2];
    assign restart_s = sync_q[3];
    assign pin_s     = sync_q[7:4];
    assign tck_rise  = tck_s & ~q.tck_d;
    assign tck_fall  = ~tck_s & q.tck_d;

    function automatic bst_tap_e tap_next(input bst_tap_e s, input logic tms);
        case (s)
            TAP_TLR:   tap_next = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI:   tap_next = tms ? TAP_SELDR : TAP_RTI;
            TAP_SELDR: tap_next = tms ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR: tap_next = tms ? TAP_EX1DR : TAP_SHDR;
            TAP_SHDR:  tap_next = tms ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR: tap_next = tms ? TAP_UPDR : TAP_PADR;
            TAP_PADR:  tap_next = tms ? TAP_EX2DR : TAP_PADR;
            TAP_EX2DR: tap_next = tms ? TAP_UPDR : TAP_SHDR;
            TAP_UPDR:  tap_next = tms ? TAP_SELDR : TAP_RTI;
            TAP_SELIR: tap_next = tms ? TAP_TLR : TAP_CAPIR;
            TAP_CAPIR: tap_next = tms ? TAP_EX1IR : TAP_SHIR;
            TAP_SHIR:  tap_next = tms ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR: tap_next = tms ? TAP_UPIR : TAP_PAIR;
            TAP_PAIR:  tap_next = tms ? TAP_EX2IR : TAP_PAIR;
            TAP_EX2IR: tap_next = tms ? TAP_UPIR : TAP_SHIR;
            TAP_UPIR:  tap_next = tms ? TAP_SELDR : TAP_RTI;
            default:   tap_next = TAP_TLR;
        endcase
    endfunction

    // instructions that take over the pins
    function automatic logic is_drive_op(input logic [`BST_IR_W-1:0] op);
        is_drive_op = (op == `BST_OP_EXTEST) || (op == `BST_OP_CLAMP) ||
                      (op == `BST_OP_HIGHZ);
    endfunction

    function automatic logic is_bsr_op(input logic [`BST_IR_W-1:0] op);
        is_bsr_op = (op == `BST_OP_SAMPLE) || (op == `BST_OP_EXTEST);
    endfunction

    always_comb begin
        nxt        = q;
        nxt.tck_d  = tck_s;
        bst_en     = q.ctrl[0] | q.scan_en;                                   // RULE8
        test_drive = bst_en & ~q.ctrl[2] & is_drive_op(q.ir);                 // RULE15
        internal   = q.ctrl[0] ? `BST_DIFF_MASK : '0;                         // RULE16
        fab_tdi    = q.proc_join ? q.proc_bit : tdi_s;                        // RULE5
        case (q.ir)
            `BST_OP_IDCODE, `BST_OP_USERCODE: dr_len = `BST_LEN_WORD;
            `BST_OP_SAMPLE, `BST_OP_EXTEST:   dr_len = `BST_LEN_BSR;
            `BST_OP_SCANEN:                   dr_len = `BST_LEN_SCANEN;       // RULE18
            `BST_OP_HALT:                     dr_len = `BST_LEN_HALT;
            default:                          dr_len = `BST_LEN_BYPASS;
        endcase
        // cells per pin: dummy, direction, data, input; dummy nearest tdo
        bsr_cap = '0;
        for (int i = 0; i < `BST_PINS; i++) begin
            bsr_cap[4*i]   = q.dr_sh[4*i];                                    // RULE4
            bsr_cap[4*i+1] = bst_en & q.pin_oe_n[i];
            bsr_cap[4*i+2] = bst_en & q.pin_out[i];
            bsr_cap[4*i+3] = bst_en & pin_s[i];
        end
        if (tck_rise) begin                                                   // RULE10
            nxt.st = tap_next(q.st, tms_s);                                   // RULE19
            case (q.st)
                TAP_CAPIR: begin
                    nxt.ir_sh    = `BST_IR_CAPTURE;                           // RULE11
                    nxt.proc_bit = 1'h0;
                end
                TAP_SHIR: begin
                    nxt.ir_sh    = {fab_tdi, q.ir_sh[`BST_IR_W-1:1]};
                    nxt.proc_bit = tdi_s;
                end
                TAP_UPIR: begin
                    // free ops always; the rest once configured or halted
                    if ((q.ir_sh == `BST_OP_BYPASS) || (q.ir_sh == `BST_OP_IDCODE) ||
                        (q.ir_sh == `BST_OP_SAMPLE) || (q.ir_sh == `BST_OP_SCANEN) ||
                        (q.ir_sh == `BST_OP_HALT) || q.ctrl[0] || q.config_halt) begin
                        nxt.ir = q.ir_sh;                                     // RULE1 RULE3
                    end else begin
                        nxt.ir = `BST_OP_BYPASS;
                    end
                end
                TAP_CAPDR: begin
                    nxt.proc_bit = 1'h0;
                    case (q.ir)
                        `BST_OP_IDCODE:   nxt.dr_sh = {2'h0, IDCODE_VALUE};
                        `BST_OP_USERCODE: nxt.dr_sh = {2'h0, q.usercode};
                        `BST_OP_SAMPLE,
                        `BST_OP_EXTEST:   nxt.dr_sh = {18'h0, bsr_cap};
                        `BST_OP_SCANEN:   nxt.dr_sh = {33'h0, q.scan_en};
                        default:          nxt.dr_sh = '0;
                    endcase
                end
                TAP_SHDR: begin
                    nxt.proc_bit = tdi_s;
                    for (int k = 0; k < `BST_DR_MAX; k++) begin
                        if (k == int'(dr_len) - 1) begin
                            nxt.dr_sh[k] = fab_tdi;
                        end else if (k < int'(dr_len) - 1) begin
                            nxt.dr_sh[k] = q.dr_sh[k+1];
                        end
                    end
                end
                TAP_UPDR: begin
                    if (is_bsr_op(q.ir) && bst_en) begin
                        for (int i = 0; i < `BST_PINS; i++) begin
                            if (!internal[i]) begin                           // RULE16
                                nxt.output_enable_update_reg[i] = q.dr_sh[4*i+1]; // RULE7
                                nxt.output_data_update_reg[i]   = q.dr_sh[4*i+2];
                            end
                        end
                    end
                    if (q.ir == `BST_OP_SCANEN) begin
                        nxt.scan_en = (q.dr_sh[7:0] == `BST_SCANEN_KEY);      // RULE18
                    end
                    if (q.ir == `BST_OP_HALT) begin
                        nxt.halt_step = (q.dr_sh == `BST_HALT_KEY1);          // RULE2
                        if (q.halt_step && (q.dr_sh == `BST_HALT_KEY2)) begin
                            nxt.halt_cmd = 1'h1;                              // RULE2
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (q.st == TAP_TLR) begin
            nxt.ir = `BST_OP_IDCODE;                                          // RULE17
        end
        if (tck_fall) begin
            if ((q.st == TAP_SHIR) || (q.st == TAP_SHDR)) begin
                nxt.tdo      = (q.st == TAP_SHIR) ? q.ir_sh[0] : q.dr_sh[0];  // RULE19
                nxt.tdo_oe_n = 1'h0;
            end else begin
                nxt.tdo_oe_n = 1'h1;
            end
        end
        // a restart of configuration drops any halt command
        if (!restart_s) begin
            nxt.halt_cmd  = 1'h0;
            nxt.halt_step = 1'h0;
        end
        nxt.config_halt = nxt.halt_cmd | ~restart_s;                          // RULE3
        nxt.proc_join   = q.ctrl[0] & q.ctrl[1];                              // RULE5
        for (int i = 0; i < `BST_PINS; i++) begin
            if (test_drive && !internal[i]) begin
                if (q.ir == `BST_OP_HIGHZ) begin
                    nxt.pin_oe_n[i] = 1'h1;
                    nxt.pin_out[i]  = q.output_data_update_reg[i];
                end else begin
                    nxt.pin_oe_n[i] = q.output_enable_update_reg[i];          // RULE14
                    nxt.pin_out[i]  = q.output_data_update_reg[i];            // RULE14
                end
            end else begin
                nxt.pin_oe_n[i] = core_oe_n[i];
                nxt.pin_out[i]  = core_out[i];
            end
        end
        // apb: one wait state, write lands on the completing edge
        nxt.pready  = apb_req.psel & apb_req.penable & ~q.pready;
        nxt.pslverr = 1'h0;
        if (apb_req.psel && apb_req.penable && !q.pready) begin
            case (apb_req.paddr)
                `BST_OFF_CTRL:     nxt.prdata = {29'h0, q.ctrl};
                `BST_OFF_STATUS:   nxt.prdata = {2'h0, q.proc_join, bst_en, q.config_halt,
                                                 q.scan_en, q.ir, q.st};
                `BST_OFF_USERCODE: nxt.prdata = q.usercode;
                `BST_OFF_IDCODE:   nxt.prdata = IDCODE_VALUE;
                `BST_OFF_PINS:     nxt.prdata = {28'h0, pin_s};
                default: begin
                    nxt.prdata  = '0;
                    nxt.pslverr = 1'h1;
                end
            endcase
        end
        if (apb_req.psel && apb_req.penable && q.pready && apb_req.pwrite) begin
            case (apb_req.paddr)
                `BST_OFF_CTRL:     nxt.ctrl     = apb_req.pwdata[2:0];
                `BST_OFF_USERCODE: nxt.usercode = apb_req.pwdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q          <= '0;
            q.st       <= TAP_TLR;
            q.ir       <= `BST_OP_IDCODE;
            q.tdo_oe_n <= 1'h1;
            q.pin_oe_n <= '1;
            q.output_enable_update_reg <= '1;
            q.ctrl     <= `BST_CTRL_RST;
            q.usercode <= `BST_USERCODE_RST;
            q.tck_d    <= 1'h0;
        end else begin
            q <= nxt;
        end
    end

    assign jtag_out                   = '{tdo: q.tdo, tdo_oe_n: q.tdo_oe_n};
    assign apb_rsp                    = '{prdata: q.prdata, pready: q.pready,
                                          pslverr: q.pslverr};
    assign config_halt                = q.config_halt;
    assign hard_processor_system_join = q.proc_join;
    assign pin_out                    = q.pin_out;
    assign pin_oe_n                   = q.pin_oe_n;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_tlr_loads_id: assert property (q.st == TAP_TLR |=> q.ir == `BST_OP_IDCODE) // RULE17
        else $error("reset state did not load id instruction");
    a_ir_capture: assert property ((q.st == TAP_CAPIR && tck_rise) |=> q.ir_sh[1:0] == 2'b01) // RULE11
        else $error("instruction capture pattern wrong");
    a_tdo_on_fall: assert property ($changed(q.tdo) |-> $past(tck_fall)) // RULE19
        else $error("tdo changed away from a falling tck edge");
    a_shdr_exit: assert property ((q.st == TAP_SHDR && tck_rise && tms_s) |=> q.st == TAP_EX1DR) // RULE19
        else $error("shift-dr did not exit on tms high");
    a_restart_halt: assert property (!restart_s |=> q.config_halt) // RULE3
        else $error("restart low did not halt configuration");
    a_free_no_halt: assert property ((q.ir != `BST_OP_HALT && restart_s && !q.halt_cmd) |=> !q.config_halt) // RULE1
        else $error("configuration halted without halt sequence");
    a_ext_drive: assert property ((test_drive && q.ir == `BST_OP_EXTEST && !internal[0] &&
        !q.output_enable_update_reg[0]) |=> (!q.pin_oe_n[0] && q.pin_out[0] == $past(q.output_data_update_reg[0]))) // RULE14
        else $error("extest pin not driven from update data");
    a_reconf_core: assert property (q.ctrl[2] |=> (q.pin_out == $past(core_out) && q.pin_oe_n == $past(core_oe_n))) // RULE15
        else $error("test drove pins during reconfiguration");
    a_scan_key: assert property ((q.st == TAP_UPDR && tck_rise && q.ir == `BST_OP_SCANEN &&
        q.dr_sh[7:0] == `BST_SCANEN_KEY) |=> q.scan_en) // RULE18
        else $error("scan-enable key did not enable circuitry");
    a_proc_wait: assert property (!q.ctrl[0] |=> !q.proc_join) // RULE5
        else $error("processor tap joined before configuration");

    c_halt_cmd: cover property ($rose(q.halt_cmd));
    c_scan_en: cover property ($rose(q.scan_en));
    c_proc_join: cover property ($rose(q.proc_join));
    c_ext_drive: cover property (test_drive && q.ir == `BST_OP_EXTEST && !q.pin_oe_n[0]);
endmodule

// ===== bst_tester.sv
/*
  model of the external scan tester: drives tck, tms, tdi, reads tdo.
  assumes the design samples tck on sys_clk; tck idles low between frames.
*/
`timescale 1ns/1ps
module bst_tester (
    // clock
    input  wire logic sys_clk,
    // link
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one tck period of 16 sys_clk, tdo taken just before the rise
    task automatic bit_io(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge sys_clk);
        q = tdo;
        tck <= 1'b1;
        repeat (8) @(posedge sys_clk);
        tck <= 1'b0;
    endtask
    // five ones then idle
    task automatic reset;
        logic q;
        for (int i = 0; i < 5; i++) bit_io(1'b1, 1'b1, q);
        bit_io(1'b0, 1'b1, q);
    endtask
    // full scan from idle back to idle
    task automatic scan(input logic ir, input int len, input logic [33:0] d,
                        output logic [33:0] cap);
        logic q;
        cap = '0;
        bit_io(1'b1, 1'b1, q);
        if (ir) bit_io(1'b1, 1'b1, q);
        bit_io(1'b0, 1'b1, q);
        bit_io(1'b0, 1'b1, q);
        for (int i = 0; i < len; i++) begin
            bit_io(i == len - 1, d[i], q);
            cap[i] = q;
        end
        bit_io(1'b1, 1'b1, q);
        bit_io(1'b0, 1'b1, q);
    endtask
endmodule

// ===== bst_tap_bench.sv
/*
  self-checking bench of bst_tap: scan scenarios and apb accesses.
  assumes bst_pkg and bst_tester are compiled before it.
*/
`timescale 1ns/1ps
`include "bst_params.svh"
module bst_tap_bench;
    import bst_pkg::*;
    logic          sys_clk, rst, config_restart_n, config_halt, join_w, tck, tms, tdi, e;
    logic [3:0]    pin_in, core_out, core_oe_n, pin_out, pin_oe_n;
    logic [33:0]   cap;
    logic [31:0]   rd;
    bst_jtag_in_s  ji;
    bst_jtag_out_s jo;
    bst_apb_req_s  req;
    bst_apb_rsp_s  rsp;
    int            err_total, compares;
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
    assign ji = {tck, tms, tdi};
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;
    bst_tap uut (.sys_clk(sys_clk), .rst(rst), .jtag_in(ji), .jtag_out(jo),
        .config_restart_n(config_restart_n), .config_halt(config_halt),
        .hard_processor_system_join(join_w), .pin_in(pin_in), .core_out(core_out),
        .core_oe_n(core_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .apb_req(req), .apb_rsp(rsp));
    bst_tester tester (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(jo.tdo));
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (rsp.pready !== 1'b1) begin
            $display("ERROR apb pready expected 1 seen %0h", rsp.pready);
            err_total++;
            complete_run;
        end else begin
            rd = rsp.prdata;
            e = rsp.pslverr;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task automatic ir(input logic [9:0] v);
        tester.scan(1'b1, 10, {24'h000000, v}, cap);
    endtask
    task automatic dr(input int n, input logic [33:0] v);
        tester.scan(1'b0, n, v, cap);
    endtask
    task automatic t_basic;
        tester.reset;
        ir(`BST_OP_BYPASS);
        `CHK("ir capture", `BST_IR_CAPTURE, cap[9:0])
        tester.reset;
        dr(32, 34'h0_0000_0000);
        `CHK("default id", 32'h0A5A_5001, cap[31:0])
        ir(`BST_OP_BYPASS);
        dr(2, 34'h0_0000_0003);
        `CHK("bypass", 2'h2, cap[1:0])
        `CHK("tdo idle", 1'b1, jo.tdo_oe_n)
        ir(`BST_OP_SAMPLE);
        apb(1'b0, `BST_OFF_STATUS, 32'h0);
        `CHK("sample loads", `BST_OP_SAMPLE, rd[25:16])
        `CHK("not halted", 1'b0, config_halt)
        `CHK("no join", 1'b0, join_w)
    endtask
    task automatic t_apb;
        apb(1'b0, `BST_OFF_USERCODE, 32'h0);
        `CHK("usercode rst", `BST_USERCODE_RST, rd)
        apb(1'b1, `BST_OFF_USERCODE, 32'h1234_5678);
        apb(1'b0, `BST_OFF_USERCODE, 32'h0);
        `CHK("usercode rw", 32'h1234_5678, rd)
        apb(1'b1, `BST_OFF_IDCODE, 32'h0);
        apb(1'b0, `BST_OFF_IDCODE, 32'h0);
        `CHK("idcode ro", 32'h0A5A_5001, rd)
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK("unmapped err", 1'b1, e)
    endtask
    task automatic t_scan_en;
        ir(`BST_OP_EXTEST);
        apb(1'b0, `BST_OFF_STATUS, 32'h0);
        `CHK("refused op", `BST_OP_BYPASS, rd[25:16])
        `CHK("scan off", 1'b0, rd[28])
        ir(`BST_OP_SCANEN);
        dr(8, 34'h0_0000_0003);
        apb(1'b0, `BST_OFF_STATUS, 32'h0);
        `CHK("wrong key", 1'b0, rd[28])
        dr(8, {26'h0, `BST_SCANEN_KEY});
        apb(1'b0, `BST_OFF_STATUS, 32'h0);
        `CHK("scan on", 1'b1, rd[28])
    endtask
    task automatic t_halt;
        config_restart_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        `CHK("restart halt", 1'b1, config_halt)
        ir(`BST_OP_EXTEST);
        apb(1'b0, `BST_OFF_STATUS, 32'h0);
        `CHK("extest loads", `BST_OP_EXTEST, rd[25:16])
        config_restart_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        `CHK("halt cleared", 1'b0, config_halt)
        ir(`BST_OP_HALT);
        dr(34, `BST_HALT_KEY1);
        dr(34, `BST_HALT_KEY2);
        `CHK("cmd halt", 1'b1, config_halt)
    endtask
    task automatic t_extest;
        ir(`BST_OP_SAMPLE);
        dr(16, 34'h0_0000_2204);
        `CHK("capture", 4'hA, {cap[15], cap[11], cap[7], cap[3]})
        ir(`BST_OP_EXTEST);
        `CHK("drive dir", 4'hC, pin_oe_n)
        `CHK("drive data", 2'h1, pin_out[1:0])
        dr(16, 34'h0_0000_2240);
        `CHK("update data", 2'h2, pin_out[1:0])
    endtask
    task automatic t_join;
        apb(1'b1, `BST_OFF_CTRL, 32'h0000_0007);
        repeat (2) @(posedge sys_clk);
        `CHK("join", 1'b1, join_w)
        tester.scan(1'b1, 11, {23'h0, 1'b1, `BST_OP_EXTEST}, cap);
        `CHK("extra bit", 11'h001, cap[10:0])
        `CHK("busy no drive", core_oe_n, pin_oe_n)
        `CHK("busy core data", core_out, pin_out)
    endtask
    task automatic complete_run;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400_000;
        err_total++;
        complete_run;
    end
    initial begin
        rst = 1'b1;
        config_restart_n = 1'b1;
        pin_in = 4'hA;
        core_out = 4'h5;
        core_oe_n = 4'h0;
        req = '0;
        err_total = 0;
        compares = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_basic;
        t_apb;
        t_scan_en;
        t_halt;
        t_extest;
        t_join;
        complete_run;
    end
endmodule
